// [core/limit_compare.sv]
// Signed or unsigned compare of a wide result's upper bits against a 16-bit limit
`timescale 1ns/1ps
module limit_compare #(
   parameter int WIDTH = 20
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_check,
   input wire logic i_signed,
   input wire logic [WIDTH-1:0] i_result,
   input wire logic [15:0] i_limit,
   output logic o_trip
);
   // ------------------------------------------------------------
   // Registered compare
   // ------------------------------------------------------------
   logic [15:0] upper;
   logic over;

   // Limit step equals result step times 2**(WIDTH-16)
   assign upper = i_result[WIDTH-1 -: 16];
   always_comb begin
      if (i_signed) begin
         over = $signed(upper) > $signed(i_limit);
      end else begin
         over = upper > i_limit;
      end
   end

   // One-cycle pulse only on a checked sample
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_trip <= 1'b0;
      end else begin
         o_trip <= i_check & over;
      end
   end
endmodule : limit_compare

// [core/power_monitor_limit.sv]
// Limit compare, result format and register file of the power monitor
`timescale 1ns/1ps
`include "pwr_mon_params.svh"
module power_monitor_limit (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire pwr_mon_pkg::sample_s i_sample,
   output pwr_mon_pkg::src_e o_conv_src,
   output logic o_conv_run,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output pwr_mon_pkg::fault_s o_fault,
   output logic o_irq
);
   import pwr_mon_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0] gen_cfg;
   logic [15:0] adc_cfg;
   logic [15:0] cur_lim;
   logic [15:0] bus_lim;
   logic [15:0] pwr_lim;
   logic signed [19:0] cur_res;
   logic signed [19:0] bus_res;
   logic signed [15:0] tmp_res;
   logic [23:0] pwr_res;
   logic signed [39:0] chg_res;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   logic pwr_check;
   logic cur_trip;
   logic bus_trip;
   logic pwr_trip;
   logic [3:0] irq_set;
   src_e next_src;
   // Decoded sample strobes, one per sampled quantity with a limit (current, bus)
   logic cur_seen;
   logic bus_seen;

   // Write decode helper
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   // Magnitude of a signed product, used for power
   function automatic logic [23:0] pwr_of(input logic signed [19:0] c,
                                          input logic signed [19:0] v);
      logic signed [39:0] p;
      logic [39:0] m;
      p = c * v;
      m = p[39] ? 40'(-p) : 40'(p);
      pwr_of = m[39:16];
   endfunction : pwr_of

   // Finished sample of one quantity; several processes key on it
   function automatic logic is_src(input sample_s s, input src_e k);
      is_src = s.valid && (s.src == k);
   endfunction : is_src

   // Sign-extend a 20-bit result onto the 32-bit read port
   // Keeps negative current and bus readings negative for the host
   function automatic logic [31:0] sext20(input logic [19:0] r);
      sext20 = {{12{r[19]}}, r};
   endfunction : sext20

   // ------------------------------------------------------------
   // Sample strobes
   // ------------------------------------------------------------
   // Decoded once so the compares, flags and sums agree on one edge
   assign cur_seen = is_src(i_sample, SRC_CUR);
   assign bus_seen = is_src(i_sample, SRC_BUS);

   // ------------------------------------------------------------
   // Configuration, reset to defaults at every power-up
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         gen_cfg <= `RST_GEN_CFG;
         adc_cfg <= `RST_ADC_CFG;
      end else if (i_wr) begin
         // Settings are lost on a power cycle; host must rewrite
         // Bit 0 of the general setting also clears the charge sum,
         // and the written value is kept for readback
         if (hit(i_addr, `OFF_GEN_CFG)) begin
            gen_cfg <= i_wdata;
         end
         if (hit(i_addr, `OFF_ADC_CFG)) begin
            adc_cfg <= i_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Fault limits, one 16-bit register each for current, bus and power
   // ------------------------------------------------------------
   // Limits reset to their loosest values, so nothing trips
   // before the host arms a threshold
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cur_lim <= `RST_CUR_LIM;
         bus_lim <= `RST_BUS_LIM;
         pwr_lim <= `RST_PWR_LIM;
      end else if (i_wr) begin
         if (hit(i_addr, `OFF_CUR_LIM)) begin
            cur_lim <= i_wdata;
         end
         if (hit(i_addr, `OFF_BUS_LIM)) begin
            bus_lim <= i_wdata;
         end
         if (hit(i_addr, `OFF_PWR_LIM)) begin
            pwr_lim <= i_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Conversion sequencing: temperature, current, bus in turn
   // ------------------------------------------------------------
   always_comb begin
      unique case (o_conv_src)
         SRC_TEMP: next_src = SRC_CUR;
         SRC_CUR: next_src = SRC_BUS;
         SRC_BUS: next_src = SRC_TEMP;
         default: next_src = SRC_TEMP;
      endcase
   end

   // Front end runs free while the run bit is set
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_conv_src <= SRC_TEMP;
         o_conv_run <= 1'b0;
      end else begin
         o_conv_run <= adc_cfg[`ADC_CFG_RUN];
         // Step only on the quantity expected, so a stray sample
         // of another source cannot skip a measurement
         if (is_src(i_sample, o_conv_src)) begin
            o_conv_src <= next_src;
         end
      end
   end

   // ------------------------------------------------------------
   // Results in two's complement, except power, an unsigned magnitude
   // ------------------------------------------------------------
   // Temperature keeps only the low 16 bits of the sample word;
   // the upper bits of that word carry nothing
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cur_res <= '0;
         bus_res <= '0;
         tmp_res <= '0;
      end else if (i_sample.valid) begin
         unique case (i_sample.src)
            SRC_CUR: cur_res <= i_sample.value;
            SRC_BUS: bus_res <= i_sample.value;
            SRC_TEMP: tmp_res <= i_sample.value[15:0];
            default: ;
         endcase
      end
   end

   // Power updates after each bus sample; charge sums current
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pwr_res <= '0;
         pwr_check <= 1'b0;
      end else begin
         // Compare one cycle later, once the new power has settled
         pwr_check <= bus_seen;
         if (bus_seen) begin
            // Uses the current stored before this bus sample
            pwr_res <= pwr_of(cur_res, i_sample.value);
         end
      end
   end

   // Charge is a signed running sum, cleared from the general config
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         chg_res <= '0;
      end else if (i_wr && hit(i_addr, `OFF_GEN_CFG) &&
                   i_wdata[`GEN_CFG_CLR_CHG]) begin
         chg_res <= '0;
      end else if (cur_seen) begin
         // Wraps silently at 40 bits; the host clears it in time
         chg_res <= chg_res + 40'(signed'(i_sample.value));
      end
   end

   // ------------------------------------------------------------
   // Limit compares
   // ------------------------------------------------------------
   // Current and bus compares are signed, so a negative limit
   // trips on any reading above it
   // Current: upper 16 of 20 bits, limit step is sixteen result steps
   limit_compare #(.WIDTH(20)) u_cur_cmp (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_check(cur_seen),
      .i_signed(1'b1),
      .i_result(i_sample.value),
      .i_limit(cur_lim),
      .o_trip(cur_trip)
   );

   // Bus voltage against the bus overvoltage limit
   limit_compare #(.WIDTH(20)) u_bus_cmp (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_check(bus_seen),
      .i_signed(1'b1),
      .i_result(i_sample.value),
      .i_limit(bus_lim),
      .o_trip(bus_trip)
   );

   // Power is a magnitude, so its compare is unsigned
   // Power is unsigned, upper 16 of 24 bits
   limit_compare #(.WIDTH(24)) u_pwr_cmp (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_check(pwr_check),
      .i_signed(1'b0),
      .i_result(pwr_res),
      .i_limit(pwr_lim),
      .o_trip(pwr_trip)
   );

   // ------------------------------------------------------------
   // Fault flags and interrupt
   // ------------------------------------------------------------
   assign irq_set = {pwr_check, pwr_trip, bus_trip, cur_trip};

   // Fault flags follow the latest compare of each quantity
   // A new sample drops the old verdict; its own compare lands
   // one cycle later and sets the flag again if still over
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_fault <= '0;
      end else begin
         if (cur_seen) begin
            o_fault.cur <= 1'b0;
         end else if (cur_trip) begin
            o_fault.cur <= 1'b1;
         end
         if (bus_seen) begin
            o_fault.bus <= 1'b0;
         end else if (bus_trip) begin
            o_fault.bus <= 1'b1;
         end
         if (pwr_trip) begin
            o_fault.pwr <= 1'b1;
         end else if (pwr_check) begin
            o_fault.pwr <= 1'b0;
         end
      end
   end

   // Sticky status, write one to clear; a new event wins the clear
   // Bit 3 marks every finished power update, tripped or not,
   // so the host can pace its reads of the power result
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= irq_set |
            (irq_stat & ~((i_wr && hit(i_addr, `OFF_IRQ_STAT)) ?
                          i_wdata[3:0] : 4'h0));
      end
   end

   // Mask of the same layout as the status bits
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_mask <= `RST_IRQ_MASK;
      end else if (i_wr && hit(i_addr, `OFF_IRQ_MASK)) begin
         irq_mask <= i_wdata[3:0];
      end
   end

   // Registered level, one cycle behind the status bit
   // Kept registered so the pin never glitches on a decode
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat & irq_mask);
      end
   end

   // ------------------------------------------------------------
   // Read port, data one cycle after the strobe, zero otherwise
   // ------------------------------------------------------------
   // 16-bit settings sit in the low half, 20-bit results are
   // sign-extended, power is zero-extended, and charge shows its
   // low 32 of 40 bits; results are read-only, writes to them drop
   // Charge must be read often enough to catch a wrap
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else if (!i_rd) begin
         o_rdata <= '0;
      end else begin
         unique case (i_addr)
            `OFF_GEN_CFG: o_rdata <= {16'h0000, gen_cfg};
            `OFF_ADC_CFG: o_rdata <= {16'h0000, adc_cfg};
            `OFF_CUR_LIM: o_rdata <= {16'h0000, cur_lim};
            `OFF_BUS_LIM: o_rdata <= {16'h0000, bus_lim};
            `OFF_PWR_LIM: o_rdata <= {16'h0000, pwr_lim};
            `OFF_CUR_RES: o_rdata <= sext20(cur_res);
            `OFF_BUS_RES: o_rdata <= sext20(bus_res);
            `OFF_PWR_RES: o_rdata <= {8'h00, pwr_res};
            `OFF_TMP_RES: o_rdata <= {{16{tmp_res[15]}}, tmp_res};
            `OFF_CHG_RES: o_rdata <= chg_res[31:0];
            `OFF_IRQ_STAT: o_rdata <= {28'h0000000, irq_stat};
            `OFF_IRQ_MASK: o_rdata <= {28'h0000000, irq_mask};
            default: o_rdata <= '0; // Unmapped reads return zero
         endcase
      end
   end
endmodule : power_monitor_limit

// [core/pwr_mon_params.svh]
// Constants for the power monitor limit and result-format block
`ifndef PWR_MON_PARAMS_SVH
`define PWR_MON_PARAMS_SVH
// Register offsets (word index on the plain register port)
`define OFF_GEN_CFG 4'h0
`define OFF_ADC_CFG 4'h1
`define OFF_CUR_LIM 4'h2
`define OFF_BUS_LIM 4'h3
`define OFF_PWR_LIM 4'h4
`define OFF_CUR_RES 4'h5
`define OFF_BUS_RES 4'h6
`define OFF_PWR_RES 4'h7
`define OFF_TMP_RES 4'h8
`define OFF_CHG_RES 4'h9
`define OFF_IRQ_STAT 4'hA
`define OFF_IRQ_MASK 4'hB
// Reset values
`define RST_GEN_CFG 16'h0000
`define RST_ADC_CFG 16'h0001
`define RST_CUR_LIM 16'h7FFF
`define RST_BUS_LIM 16'h7FFF
`define RST_PWR_LIM 16'hFFFF
`define RST_IRQ_MASK 4'h0
// Field positions
`define ADC_CFG_RUN 0
`define GEN_CFG_CLR_CHG 0
`define IRQ_CUR 0
`define IRQ_BUS 1
`define IRQ_PWR 2
`define IRQ_DONE 3
// Alignment of limits against results
`define CUR_LIM_SHIFT 4
`define PWR_LIM_SHIFT 8
`endif

// [core/pwr_mon_pkg.sv]
// Types shared by the power monitor limit block
package pwr_mon_pkg;
   typedef enum logic [1:0] {SRC_TEMP, SRC_CUR, SRC_BUS} src_e;
   // One finished conversion from the converter front end
   typedef struct packed {
      logic valid;
      src_e src;
      logic [19:0] value;
   } sample_s;
   // Over-limit flags in status-bit order
   typedef struct packed {
      logic pwr;
      logic bus;
      logic cur;
   } fault_s;
endpackage : pwr_mon_pkg

// [tb/conv_model.sv]
// Converter front-end model feeding finished samples to the block
`timescale 1ns/1ps
module conv_model
   import pwr_mon_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire pwr_mon_pkg::src_e i_conv_src,
   input wire logic i_conv_run,
   input wire logic i_go,
   input wire logic [19:0] i_value,
   output pwr_mon_pkg::sample_s o_sample
);
   // One pulse per conversion in sequencer order; value scrambled
   // between pulses so a stale value is never trusted
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sample <= '0;
      end else if (i_go && i_conv_run) begin
         o_sample <= {1'b1, i_conv_src, i_value};
      end else begin
         o_sample.valid <= 1'b0;
         o_sample.value <= ~o_sample.value;
      end
   end
endmodule : conv_model

// [tb/pwr_mon_chk.sv]
// Port-level assertions for the power monitor limit block
`timescale 1ns/1ps
`include "pwr_mon_params.svh"
module pwr_mon_chk
   import pwr_mon_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire pwr_mon_pkg::sample_s i_sample,
   input wire pwr_mon_pkg::src_e o_conv_src,
   input wire logic o_conv_run,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire pwr_mon_pkg::fault_s o_fault,
   input wire logic o_irq
);
   logic [15:0] cur_lim, bus_lim, pwr_lim, lim_rd;
   logic [3:0] mask;
   logic [19:0] cur_val;
   logic signed [39:0] prod;
   logic [39:0] mag;
   logic hit_c, hit_b, hit_p;
   // Mirror of host-written limits and mask
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cur_lim <= `RST_CUR_LIM;
         bus_lim <= `RST_BUS_LIM;
         pwr_lim <= `RST_PWR_LIM;
         mask <= `RST_IRQ_MASK;
      end else if (i_wr) begin
         if (i_addr == `OFF_CUR_LIM) cur_lim <= i_wdata;
         if (i_addr == `OFF_BUS_LIM) bus_lim <= i_wdata;
         if (i_addr == `OFF_PWR_LIM) pwr_lim <= i_wdata;
         if (i_addr == `OFF_IRQ_MASK) mask <= i_wdata[3:0];
      end
   end
   // Last current sample, the one power is built from
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) cur_val <= 20'h0;
      else if (i_sample.valid && i_sample.src == SRC_CUR)
         cur_val <= i_sample.value;
   end
   // Expected trips, judged at the sample edge
   assign prod = $signed(cur_val) * $signed(i_sample.value);
   assign mag = prod[39] ? 40'(-prod) : 40'(prod);
   assign hit_c = $signed(i_sample.value[19:4]) > $signed(cur_lim);
   assign hit_b = $signed(i_sample.value[19:4]) > $signed(bus_lim);
   assign hit_p = mag[39:24] > pwr_lim;
   assign lim_rd = i_addr == `OFF_CUR_LIM ? cur_lim :
      i_addr == `OFF_BUS_LIM ? bus_lim : pwr_lim;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_cur; i_sample.valid && i_sample.src == SRC_CUR; endsequence
   sequence s_bus; i_sample.valid && i_sample.src == SRC_BUS; endsequence
   sequence s_lim;
      i_rd && i_addr >= `OFF_CUR_LIM && i_addr <= `OFF_PWR_LIM;
   endsequence
   property p_cur; s_cur |-> ##3 o_fault.cur == $past(hit_c, 3); endproperty
   property p_bus; s_bus |-> ##3 o_fault.bus == $past(hit_b, 3); endproperty
   property p_pwr; s_bus |-> ##4 o_fault.pwr == $past(hit_p, 4); endproperty
   property p_lim;
      s_lim |=> o_rdata == {16'h0, $past(lim_rd)};
   endproperty
   property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
   property p_run;
      i_wr && i_addr == `OFF_ADC_CFG |-> ##2 o_conv_run == $past(i_wdata[0], 2);
   endproperty
   property p_mask; mask == 4'h0 |=> !o_irq; endproperty
   property p_src;
      $changed(o_conv_src) |-> $past(i_sample.valid) || $past(i_sample.valid, 2);
   endproperty
   a_cur: assert property (p_cur) else $error("cur fault wrong");
   a_bus: assert property (p_bus) else $error("bus fault wrong");
   a_pwr: assert property (p_pwr) else $error("pwr fault wrong");
   a_lim: assert property (p_lim) else $error("limit readback");
   a_idle: assert property (p_idle) else $error("rdata not zero");
   a_run: assert property (p_run) else $error("run level wrong");
   a_mask: assert property (p_mask) else $error("masked irq");
   a_src: assert property (p_src) else $error("src moved");
endmodule : pwr_mon_chk
bind power_monitor_limit pwr_mon_chk u_chk (.i_ref_clk, .i_nrst, .i_sample,
   .o_conv_src, .o_conv_run, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .o_fault, .o_irq);

// [tb/testbench.sv]
// Self-checking bench for the power monitor limit block
`timescale 1ns/1ps
`include "pwr_mon_params.svh"
module testbench;
   import pwr_mon_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic go = 1'b0;
   logic [19:0] val = 20'h0;
   sample_s smp;
   src_e src;
   logic run, irq;
   logic [31:0] rdata;
   fault_s fault;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   logic [15:0] cl, bl, pl;
   logic [19:0] cv, bv, tv;
   // Host-side current step in microamperes per count
   localparam int CUR_STEP_UA = 75;
   power_monitor_limit u_dut (.i_ref_clk, .i_nrst, .i_sample(smp),
      .o_conv_src(src), .o_conv_run(run), .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata(rdata), .o_fault(fault), .o_irq(irq));
   conv_model u_conv (.i_ref_clk, .i_nrst, .i_conv_src(src),
      .i_conv_run(run), .i_go(go), .i_value(val), .o_sample(smp));
   initial begin
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   task automatic report_and_stop;
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // Hang guard, well above the roughly 1500 cycles the run needs
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic cmp(input logic [31:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : cmp
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e, string m);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 cmp(rdata, e, m);
   endtask : rd
   // One conversion, then long enough for power fault and irq to land
   task automatic send(input logic [19:0] v);
      @(posedge i_ref_clk);
      go <= 1'b1;
      val <= v;
      @(posedge i_ref_clk);
      go <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      #1;
   endtask : send
   function automatic logic trip(input logic [19:0] v, input logic [15:0] l);
      return $signed(v[19:4]) > $signed(l);
   endfunction : trip
   function automatic logic ptrip(input logic [19:0] c, b, input logic [15:0] l);
      logic signed [39:0] p;
      p = $signed(c) * $signed(b);
      if (p < 0) p = -p;
      return p[39:24] > l;
   endfunction : ptrip
   // Expected power word: magnitude of the product, bits 39..16
   function automatic logic [23:0] pval(input logic [19:0] c, b);
      logic signed [39:0] p;
      p = $signed(c) * $signed(b);
      if (p < 0) p = -p;
      return p[39:16];
   endfunction : pval
   // Host scaling of a raw current word into microamperes
   function automatic int to_ua(input logic [31:0] raw);
      return int'($signed(raw)) * CUR_STEP_UA;
   endfunction : to_ua
   // Corner values around the limit and at negative full scale, else random
   function automatic logic [19:0] pick(input int k, input logic [15:0] l);
      case (k % 4)
         0: return {l, 4'hF};
         1: return {l + 16'h1, 4'h0};
         2: return 20'h80000;
         default: return 20'($urandom);
      endcase
   endfunction : pick
   task automatic defaults;
      rd(`OFF_GEN_CFG, {16'h0, `RST_GEN_CFG}, "gen");
      rd(`OFF_ADC_CFG, {16'h0, `RST_ADC_CFG}, "adc");
      rd(`OFF_CUR_LIM, {16'h0, `RST_CUR_LIM}, "cur lim");
      rd(`OFF_BUS_LIM, {16'h0, `RST_BUS_LIM}, "bus lim");
      rd(`OFF_PWR_LIM, {16'h0, `RST_PWR_LIM}, "pwr lim");
      rd(`OFF_IRQ_MASK, 32'h0, "mask");
      rd(4'hC, 32'h0, "unmapped");
      cmp(32'(run), 32'h1, "run");
      cmp(32'(src), 32'(SRC_TEMP), "src");
   endtask : defaults
   initial begin
      void'($urandom(32'hF671D748));
      repeat (20) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      defaults();
      for (int i = 0; i < 40; i++) begin
         cl = 16'($urandom);
         bl = 16'($urandom);
         pl = (i % 3 == 0) ? 16'h0 : 16'($urandom);
         wr(`OFF_CUR_LIM, cl);
         wr(`OFF_BUS_LIM, bl);
         wr(`OFF_PWR_LIM, pl);
         rd(`OFF_BUS_LIM, {16'h0, bl}, "lim rd");
         tv = 20'($urandom);
         send(tv);
         cmp(32'(src), 32'(SRC_CUR), "src cur");
         rd(`OFF_TMP_RES, 32'($signed(tv[15:0])), "tmp res");
         cv = pick(i, cl);
         send(cv);
         cmp(32'(fault.cur), 32'(trip(cv, cl)), "cur fault");
         rd(`OFF_CUR_RES, 32'($signed(cv)), "cur res");
         bv = pick(i + 1, bl);
         send(bv);
         cmp(32'(fault.bus), 32'(trip(bv, bl)), "bus fault");
         cmp(32'(fault.pwr), 32'(ptrip(cv, bv, pl)), "pwr");
         rd(`OFF_PWR_RES, {8'h00, pval(cv, bv)}, "pwr res");
         rd(`OFF_BUS_RES, 32'($signed(bv)), "bus res");
         cmp(32'(src), 32'(SRC_TEMP), "src temp");
      end
      // Interrupt: masked, unmasked, then cleared
      wr(`OFF_IRQ_STAT, 16'h000F);
      wr(`OFF_CUR_LIM, 16'h0000);
      send(20'h0);
      send(20'h00100);
      cmp(32'(irq), 32'h0, "irq masked");
      rd(`OFF_IRQ_STAT, 32'h1, "stat");
      wr(`OFF_IRQ_MASK, 16'h0001);
      @(posedge i_ref_clk);
      #1 cmp(32'(irq), 32'h1, "irq on");
      wr(`OFF_IRQ_STAT, 16'h0001);
      @(posedge i_ref_clk);
      #1 cmp(32'(irq), 32'h0, "irq clr");
      send(20'h0);
      // Converter halted: no sample, no sequencer step
      wr(`OFF_ADC_CFG, 16'h0000);
      @(posedge i_ref_clk);
      #1 cmp(32'(run), 32'h0, "run off");
      send(20'h0);
      cmp(32'(src), 32'(SRC_TEMP), "src held");
      wr(`OFF_ADC_CFG, 16'h0001);
      // Power cycle in mid-run, then the host programs again
      @(posedge i_ref_clk);
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      defaults();
      wr(`OFF_CUR_LIM, 16'h1234);
      rd(`OFF_CUR_LIM, 32'h1234, "relimit");
      // Known current, host scaling, charge sum, clear, done bit
      send(20'h0);
      send(20'h3A980);
      rd(`OFF_CUR_RES, 32'h0003A980, "cur 18 A");
      cmp(32'(to_ua(rdata)), 32'd18000000, "host scale");
      rd(`OFF_CHG_RES, 32'h0003A980, "chg");
      wr(`OFF_GEN_CFG, 16'h0001);
      rd(`OFF_CHG_RES, 32'h0, "chg clr");
      send(20'h0);
      rd(`OFF_IRQ_STAT, 32'h9, "stat done");
      send(20'h0);
      send(20'h80000);
      rd(`OFF_CHG_RES, 32'hFFF80000, "chg neg");
      report_and_stop();
   end
endmodule : testbench
